// [include/dtc_pkg.sv]
// Package: constants, register map and carrier types for the dual timer/counter
package dtc_pkg;

	// Machine cycle length in aclk periods (one aclk stands for one oscillator period)
	localparam int unsigned OSC_PER_MCYC = 6;
	localparam logic [2:0]  MCYC_LAST    = 3'(OSC_PER_MCYC - 1);
	localparam logic [4:0]  PRESC_LAST   = 5'h1F; // Divide-by-32 prescaler

	// Mode field encodings
	typedef enum logic [1:0] {
		DTC_MODE_13  = 2'h0,
		DTC_MODE_16  = 2'h1,
		DTC_MODE_RLD = 2'h2,
		DTC_MODE_SPL = 2'h3
	} dtc_mode_t;

	// Per-counter configuration nibble (mode, timer/counter select, gate enable)
	typedef struct packed {
		logic      gate_en;
		logic      count_sel; // 1 = counter function on count input
		dtc_mode_t mode;
	} dtc_cfg_t;

	// Word offsets on the AXI4-Lite bus
	localparam logic [4:0] ADDR_MODE   = 5'h00; // counter_mode_register
	localparam logic [4:0] ADDR_RUN    = 5'h04; // Run bits
	localparam logic [4:0] ADDR_CNT0   = 5'h08; // Counter 0 {high,low}
	localparam logic [4:0] ADDR_CNT1   = 5'h0C; // Counter 1 {high,low}
	localparam logic [4:0] ADDR_STAT   = 5'h10; // Sticky overflow flags
	localparam logic [4:0] ADDR_MASK   = 5'h14; // Interrupt mask

	// Field layout
	localparam int unsigned CFG0_LSB = 0;
	localparam int unsigned CFG1_LSB = 4;
	localparam int unsigned NFLAG    = 3; // ovf0, ovf1, split high byte ovf
	localparam logic [1:0]  RESP_OK     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Counter pair state
	typedef struct packed {
		logic [7:0] hi;
		logic [7:0] lo;
	} dtc_cnt_t;

endpackage

// [rtl/dtc_unit.sv]
// One timer/counter channel: low and high byte with four modes
`timescale 1ns/100ps
module dtc_unit (
	// Clock and reset
	input  wire logic          aclk,
	input  wire logic          aresetn,
	input  wire logic          ce,
	// Control
	input  wire logic          mcyc_tick,
	input  wire logic          cnt_edge,
	input  wire logic          gate_ok,
	input  wire logic          run,
	input  wire dtc_pkg::dtc_cfg_t cfg,
	input  wire logic          halt,
	input  wire logic          hi_run,
	// Software load
	input  wire logic          wr_en,
	input  wire dtc_pkg::dtc_cnt_t wr_val,
	// Results
	output dtc_pkg::dtc_cnt_t  cnt,
	output logic               ovf,
	output logic               hi_ovf
);

	typedef struct packed {
		dtc_pkg::dtc_cnt_t c;
		logic [4:0]        pre;
		logic              ovf;
		logic              hi_ovf;
	} dtc_unit_st_t;

	dtc_unit_st_t s_q;
	dtc_unit_st_t s_d;
	logic         inc;

	// Increment source: machine cycle or detected count edge, gated
	assign inc = run && gate_ok && !halt &&
		(cfg.count_sel ? cnt_edge : mcyc_tick);

	// Next-state logic for the four modes
	always_comb begin
		s_d        = s_q;
		s_d.ovf    = 1'b0;
		s_d.hi_ovf = 1'b0;
		if (inc) begin
			unique case (cfg.mode)
				dtc_pkg::DTC_MODE_13: begin
					s_d.pre = s_q.pre + 5'h01;
					if (s_q.pre == dtc_pkg::PRESC_LAST) begin
						s_d.c.hi = s_q.c.hi + 8'h01;
						s_d.ovf  = (s_q.c.hi == 8'hFF);
					end
				end
				dtc_pkg::DTC_MODE_16: begin
					{s_d.c.hi, s_d.c.lo} = {s_q.c.hi, s_q.c.lo} + 16'h0001;
					s_d.ovf = ({s_q.c.hi, s_q.c.lo} == 16'hFFFF);
				end
				dtc_pkg::DTC_MODE_RLD: begin
					// Reload low byte from high byte on rollover
					if (s_q.c.lo == 8'hFF) begin
						s_d.c.lo = s_q.c.hi;
						s_d.ovf  = 1'b1;
					end else begin
						s_d.c.lo = s_q.c.lo + 8'h01;
					end
				end
				dtc_pkg::DTC_MODE_SPL: begin
					// Low byte is the 8-bit timer/counter
					s_d.c.lo = s_q.c.lo + 8'h01;
					s_d.ovf  = (s_q.c.lo == 8'hFF);
				end
			endcase
		end
		// Split mode high byte: pure timer on machine cycles
		if (cfg.mode == dtc_pkg::DTC_MODE_SPL && hi_run && mcyc_tick) begin
			s_d.c.hi   = s_q.c.hi + 8'h01;
			s_d.hi_ovf = (s_q.c.hi == 8'hFF);
		end
		// Software write wins over counting; prescaler restarts
		if (wr_en) begin
			s_d.c   = wr_val;
			s_d.pre = 5'h00;
		end
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign cnt    = s_q.c;
	assign ovf    = s_q.ovf;
	assign hi_ovf = s_q.hi_ovf;

endmodule // dtc_unit

// [rtl/dtc_top.sv]
// Dual timer/counter with AXI4-Lite registers and overflow interrupt
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
module dtc_top (
	// Clock, reset, enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	// External count and gate pins
	input  wire logic        count_input_zero,
	input  wire logic        count_input_one,
	input  wire logic        gate_input_zero,
	input  wire logic        gate_input_one,
	// AXI4-Lite write address and data
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [4:0]  s_axi_awaddr,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// AXI4-Lite read
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [4:0]  s_axi_araddr,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// Interrupt
	output logic             irq
);

	typedef struct packed {
		logic [2:0]  phase;     // Machine cycle phase
		logic [1:0]  pin_s;     // Count pin samples, last machine cycle
		logic [1:0]  pin_p;     // Count pin samples, one earlier
		logic [7:0]  mode_reg;  // Two config nibbles
		logic [1:0]  run;
		logic [dtc_pkg::NFLAG-1:0] stat;
		logic [dtc_pkg::NFLAG-1:0] mask;
		logic        aw_got;
		logic [4:0]  aw_addr;
		logic        w_got;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic        irq;
	} dtc_top_st_t;

	dtc_top_st_t        s_q;
	dtc_top_st_t        s_d;
	dtc_pkg::dtc_cfg_t  cfg [2];
	dtc_pkg::dtc_cnt_t  cnt [2];
	logic [1:0]         ovf;
	logic [1:0]         hi_ovf;
	logic [1:0]         edge_hit;
	logic [1:0]         gate_ok;
	logic [1:0]         wr_cnt;
	logic               mcyc_tick;
	logic               do_write;
	dtc_pkg::dtc_cnt_t  wr_val;
	logic [1:0]         pins;
	logic [1:0]         gpins;

	// Apply byte strobes to a stored word
	function automatic logic [31:0] strb_merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) r[8*b +: 8] = nw[8*b +: 8];
		end
		return r;
	endfunction

	// Machine cycle tick every six clocks
	assign mcyc_tick = (s_q.phase == dtc_pkg::MCYC_LAST);
	assign pins      = {count_input_one, count_input_zero};
	assign gpins     = {gate_input_one, gate_input_zero};
	assign do_write  = s_q.aw_got && s_q.w_got && !s_q.bvalid;
	assign wr_val    = dtc_pkg::dtc_cnt_t'(s_q.w_data[15:0]);

	// Per-channel edge detect, gating, config and counter units
	for (genvar i = 0; i < 2; i++) begin : g_ch
		// Falling edge seen across two machine-cycle samples
		assign edge_hit[i] = mcyc_tick && s_q.pin_p[i] && !s_q.pin_s[i];
		// Gate pin high lets counting proceed when gating enabled
		assign gate_ok[i]  = !cfg[i].gate_en || gpins[i];
		assign cfg[i]      = dtc_pkg::dtc_cfg_t'(s_q.mode_reg[4*i +: 4]);
		assign wr_cnt[i]   = do_write && (s_q.aw_addr ==
			(i == 0 ? dtc_pkg::ADDR_CNT0 : dtc_pkg::ADDR_CNT1));

		dtc_unit u_unit (
			.aclk      (aclk),
			.aresetn   (aresetn),
			.ce        (ce),
			.mcyc_tick (mcyc_tick),
			.cnt_edge  (edge_hit[i]),
			.gate_ok   (gate_ok[i]),
			.run       (s_q.run[i]),
			.cfg       (cfg[i]),
			// Counter 1 stops while counter 0 is split
			.halt      (i == 1 && cfg[0].mode == dtc_pkg::DTC_MODE_SPL),
			.hi_run    (i == 0 && s_q.run[1]),
			.wr_en     (wr_cnt[i]),
			.wr_val    (wr_val),
			.cnt       (cnt[i]),
			.ovf       (ovf[i]),
			.hi_ovf    (hi_ovf[i])
		);
	end

	// Bus handshake, registers, sticky flags and interrupt
	always_comb begin
		logic [31:0] wm;
		logic [2:0]  ev;
		wm  = '0;
		ev  = {hi_ovf[0], ovf[1], ovf[0]};
		s_d = s_q;
		s_d.phase = mcyc_tick ? 3'h0 : s_q.phase + 3'h1;
		if (mcyc_tick) begin
			// Sample pins once per machine cycle
			s_d.pin_p = s_q.pin_s;
			s_d.pin_s = pins;
		end
		// Write address and data taken independently
		if (s_axi_awvalid && !s_q.aw_got) begin
			s_d.aw_got  = 1'b1;
			s_d.aw_addr = {s_axi_awaddr[4:2], 2'b00};
		end
		if (s_axi_wvalid && !s_q.w_got) begin
			s_d.w_got  = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		if (do_write) begin
			s_d.bvalid = 1'b1;
			s_d.bresp  = dtc_pkg::RESP_OK;
			unique case (s_q.aw_addr)
				dtc_pkg::ADDR_MODE: begin
					wm = strb_merge({24'h0, s_q.mode_reg}, s_q.w_data,
						s_q.w_strb);
					s_d.mode_reg = wm[7:0];
				end
				dtc_pkg::ADDR_RUN: begin
					wm = strb_merge({30'h0, s_q.run}, s_q.w_data, s_q.w_strb);
					s_d.run = wm[1:0];
				end
				dtc_pkg::ADDR_MASK: begin
					wm = strb_merge({29'h0, s_q.mask}, s_q.w_data, s_q.w_strb);
					s_d.mask = wm[2:0];
				end
				dtc_pkg::ADDR_STAT: begin
					if (s_q.w_strb[0]) s_d.stat = s_q.stat & ~s_q.w_data[2:0];
				end
				dtc_pkg::ADDR_CNT0, dtc_pkg::ADDR_CNT1: ;
				default: s_d.bresp = dtc_pkg::RESP_SLVERR;
			endcase
		end
		// Events set after the clear so a same-cycle event survives
		s_d.stat = s_d.stat | ev;
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
			s_d.aw_got = 1'b0;
			s_d.w_got  = 1'b0;
		end
		// Read channel
		if (s_axi_arvalid && !s_q.rvalid) begin
			s_d.rvalid = 1'b1;
			s_d.rresp  = dtc_pkg::RESP_OK;
			unique case ({s_axi_araddr[4:2], 2'b00})
				dtc_pkg::ADDR_MODE: s_d.rdata = {24'h0, s_q.mode_reg};
				dtc_pkg::ADDR_RUN:  s_d.rdata = {30'h0, s_q.run};
				dtc_pkg::ADDR_CNT0: s_d.rdata = {16'h0, cnt[0]};
				dtc_pkg::ADDR_CNT1: s_d.rdata = {16'h0, cnt[1]};
				dtc_pkg::ADDR_STAT: s_d.rdata = {29'h0, s_q.stat};
				dtc_pkg::ADDR_MASK: s_d.rdata = {29'h0, s_q.mask};
				default: begin
					s_d.rdata = 32'h0000_0000;
					s_d.rresp = dtc_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		s_d.irq = |(s_d.stat & s_d.mask);
	end

	// State register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// Outputs straight from flip-flops
	assign s_axi_awready = !s_q.aw_got;
	assign s_axi_wready  = !s_q.w_got;
	assign s_axi_bvalid  = s_q.bvalid;
	assign s_axi_bresp   = s_q.bresp;
	assign s_axi_arready = !s_q.rvalid;
	assign s_axi_rvalid  = s_q.rvalid;
	assign s_axi_rdata   = s_q.rdata;
	assign s_axi_rresp   = s_q.rresp;
	assign irq           = s_q.irq;

endmodule // dtc_top

// [test/dtc_pins.sv]
// Pin-side source model: count pulses and gate levels
`timescale 1ns/100ps
module dtc_pins (
	// Clock
	input  wire logic aclk,
	// Pins
	output logic      count_input_zero,
	output logic      count_input_one,
	output logic      gate_input_zero,
	output logic      gate_input_one
);
	// Count pins idle high so the first drop is a real edge
	initial begin
		count_input_zero = 1'h1;
		count_input_one = 1'h1;
		gate_input_zero = 1'h0;
		gate_input_one = 1'h0;
	end
	// Six clocks a level: the fastest rate the sampler can see
	task automatic pulse(input int ch, input int n);
		repeat (n) begin
			repeat (6) @(posedge aclk);
			if (ch) count_input_one <= 1'h0;
			else count_input_zero <= 1'h0;
			repeat (6) @(posedge aclk);
			if (ch) count_input_one <= 1'h1;
			else count_input_zero <= 1'h1;
		end
	endtask
	// Gate level for one counter
	task automatic gate(input int ch, input logic v);
		@(posedge aclk);
		if (ch) gate_input_one <= v;
		else gate_input_zero <= v;
	endtask
endmodule // dtc_pins

// [test/dtc_asserts.sv]
// Bus and interrupt checker bound to the timer/counter top
`timescale 1ns/100ps
module dtc_asserts (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Write channels
	input  wire logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	input  wire logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// Read channels
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic [31:0] s_axi_rdata,
	// Interrupt
	input  wire logic        irq
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Write side timing
	chk_b_delay: assert property (s_axi_awvalid && s_axi_awready
		&& s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	chk_aw_busy: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready) else $error("aw not held");
	chk_ready_back: assert property (s_axi_bvalid && s_axi_bready
		|-> ##[1:2] (s_axi_awready && s_axi_wready))
		else $error("write side not freed");
	// Read side timing
	chk_r_delay: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid) else $error("read answer late");
	chk_ar_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("ar taken while busy");
	chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_r_done: assert property (s_axi_rvalid && s_axi_rready
		|=> !s_axi_rvalid) else $error("read answer stuck");
	// Only a write can clear the interrupt; the clear and the answer
	// come from the same register update, so they appear on one edge
	chk_irq_fall: assert property ($fell(irq)
		|-> $rose(s_axi_bvalid))
		else $error("irq fell with no write");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property ($rose(irq));
endmodule // dtc_asserts
bind dtc_top dtc_asserts u_dtc_asserts (.*);

// [test/dtc_top_bench.sv]
// Self-checking bench for the dual timer/counter
`timescale 1ns/100ps
module dtc_top_bench;
	logic        aclk = 1'h0;
	logic        aresetn = 1'h0;
	logic        ce = 1'h1;
	logic        s_axi_awvalid = 1'h0;
	logic        s_axi_wvalid = 1'h0;
	logic        s_axi_bready = 1'h0;
	logic        s_axi_arvalid = 1'h0;
	logic        s_axi_rready = 1'h0;
	logic [4:0]  s_axi_awaddr = 5'h00;
	logic [4:0]  s_axi_araddr = 5'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid, irq;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        count_input_zero, count_input_one;
	logic        gate_input_zero, gate_input_one;
	int          bad_count = 0;
	int          checks = 0;
	dtc_top u_dtc_top (.s_axi_wstrb(4'hF), .*);
	dtc_pins u_dtc_pins (.*);
	always #25 aclk = ~aclk;
	// Count and report one comparison
	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'h1) begin
			bad_count++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	// Bus write, both halves offered together
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
		end while (!s_axi_bvalid && n < 99);
		s_axi_bready <= 1'h0;
		// Offsets past the map must answer with a slave error
		chk(n < 99 && s_axi_bresp === (a > dtc_pkg::ADDR_MASK ?
			dtc_pkg::RESP_SLVERR : dtc_pkg::RESP_OK), "write");
	endtask
	// Bus read; ready raised late so the answer must hold
	task automatic rd(input logic [4:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
		end while (!s_axi_rvalid && n < 99);
		s_axi_rready <= 1'h1;
		@(posedge aclk);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'h0;
		chk(n < 99, "read");
	endtask
	// Byte of a register against a window; slack covers bus latency
	task automatic rng(input logic [4:0] a, input int sh, lo, hi);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		chk(d[sh+:8] >= lo && d[sh+:8] <= hi && r === 2'h0, "count");
	endtask
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 6; i++)
			rng(5'(4 * i), 0, 0, 0);
		// First offset past the map reads zero with an error
		rd(5'h18, d, r);
		chk(d === 32'h0 && r === dtc_pkg::RESP_SLVERR, "unmapped read");
		wr(5'h18, 32'h0);
		chk(irq === 1'h0, "reset irq");
		$display("reset test done");
	endtask
	task automatic t_timer;
		wr(dtc_pkg::ADDR_MODE, 32'h1);
		wr(dtc_pkg::ADDR_CNT0, 32'hFC);
		wr(dtc_pkg::ADDR_RUN, 32'h1);
		repeat (60) @(posedge aclk);
		rng(dtc_pkg::ADDR_CNT0, 8, 1, 1);
		wr(dtc_pkg::ADDR_MODE, 32'h0);
		wr(dtc_pkg::ADDR_CNT0, 32'h0);
		repeat (420) @(posedge aclk);
		rng(dtc_pkg::ADDR_CNT0, 8, 2, 2);
		$display("timer test done");
	endtask
	task automatic t_reload;
		wr(dtc_pkg::ADDR_STAT, 32'h7);
		wr(dtc_pkg::ADDR_MODE, 32'h2);
		wr(dtc_pkg::ADDR_CNT0, 32'hF0FE);
		repeat (60) @(posedge aclk);
		rng(dtc_pkg::ADDR_CNT0, 0, 'hF5, 'hFB);
		rng(dtc_pkg::ADDR_CNT0, 8, 'hF0, 'hF0);
		chk(irq === 1'h0, "masked irq");
		wr(dtc_pkg::ADDR_MASK, 32'h1);
		repeat (3) @(posedge aclk);
		chk(irq === 1'h1, "irq");
		wr(dtc_pkg::ADDR_RUN, 32'h0);
		wr(dtc_pkg::ADDR_STAT, 32'h7);
		repeat (3) @(posedge aclk);
		chk(irq === 1'h0, "irq clear");
		$display("reload test done");
	endtask
	task automatic t_split;
		logic [31:0] d;
		logic [31:0] e;
		logic [1:0]  r;
		wr(dtc_pkg::ADDR_CNT1, 32'h1234);
		wr(dtc_pkg::ADDR_MODE, 32'h13);
		wr(dtc_pkg::ADDR_CNT0, 32'h0);
		wr(dtc_pkg::ADDR_RUN, 32'h3);
		repeat (60) @(posedge aclk);
		rng(dtc_pkg::ADDR_CNT1, 0, 'h34, 'h34);
		rng(dtc_pkg::ADDR_CNT0, 8, 8, 13);
		rng(dtc_pkg::ADDR_CNT0, 0, 8, 14);
		// High byte at its top wraps within one machine cycle
		wr(dtc_pkg::ADDR_CNT0, 32'hFF00);
		repeat (8) @(posedge aclk);
		rng(dtc_pkg::ADDR_STAT, 0, 4, 4);
		// Enable low must freeze counting; sixty clocks pass while it is low
		rd(dtc_pkg::ADDR_CNT0, d, r);
		@(posedge aclk);
		ce <= 1'h0;
		repeat (60) @(posedge aclk);
		ce <= 1'h1;
		rd(dtc_pkg::ADDR_CNT0, e, r);
		chk(8'(e[7:0] - d[7:0]) <= 8'h1, "enable freeze");
		$display("split test done");
	endtask
	task automatic t_count;
		wr(dtc_pkg::ADDR_RUN, 32'h0);
		wr(dtc_pkg::ADDR_MODE, 32'hD5);
		wr(dtc_pkg::ADDR_CNT0, 32'h0);
		wr(dtc_pkg::ADDR_CNT1, 32'h0);
		u_dtc_pins.gate(1, 1'h1);
		wr(dtc_pkg::ADDR_RUN, 32'h3);
		u_dtc_pins.pulse(1, 5);
		u_dtc_pins.pulse(0, 4);
		repeat (18) @(posedge aclk);
		rng(dtc_pkg::ADDR_CNT1, 0, 5, 5);
		rng(dtc_pkg::ADDR_CNT0, 0, 4, 4);
		u_dtc_pins.gate(1, 1'h0);
		u_dtc_pins.pulse(1, 3);
		repeat (18) @(posedge aclk);
		rng(dtc_pkg::ADDR_CNT1, 0, 5, 5);
		$display("count test done");
	endtask
	// Print counts and the verdict, then stop
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Hang guard, well past the thousand or so cycles of the tests
	initial begin
		repeat (20000) @(posedge aclk);
		bad_count++;
		give_verdict;
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		t_reset;
		t_timer;
		t_reload;
		t_split;
		t_count;
		give_verdict;
	end
endmodule // dtc_top_bench
